// File: icad_pkg.sv
// Functional notes
// [RULE1] Config registers reached only via index/data ports.
// [RULE2] Port pair base from strap, software relocatable.
// [RULE3] Two base straps choose one of four bases.
// [RULE4] Config strap picks one of four defaults.
// [RULE5] Decode address; DMA acknowledge overrides address lines.
// [RULE6] Address enable high blocks all address selection.
// [RULE7] Narrow or wide decode; selects need wide.
// [RULE8] Two programmable selects: chip, latch, output enable.
// [RULE9] Function bases fully programmable over sixteen bits.
// [RULE10] Software writes index, then accesses data port.
`default_nettype none

package icad_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes of the configuration space.
  localparam int NREG     = 32;
  localparam int IDX_W    = 5;
  localparam int NFUNC    = 4;
  localparam int NPS      = 2;
  localparam int PS_STEP  = 4;
  localparam int FB_STEP  = 2;

  // Configuration register indices.
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CFGB_LO = 8'h01;
  localparam logic [7:0] REG_CFGB_HI = 8'h02;
  localparam logic [7:0] REG_STRAP   = 8'h03;
  localparam logic [7:0] REG_FB      = 8'h04;
  localparam logic [7:0] REG_PS      = 8'h10;

  // Field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FEN_LSB  = 4;
  localparam int PS_KIND_LSB   = 0;
  localparam int PS_EN_BIT     = 2;
  localparam int STRAP_BS_LSB  = 0;
  localparam int STRAP_CFG_LSB = 2;

  // Decode widths and their compare masks.
  localparam logic [1:0]  MODE_NARROW = 2'h0;
  localparam logic [1:0]  MODE_WIDE   = 2'h1;
  localparam logic [1:0]  MODE_FULL   = 2'h2;
  localparam logic [15:0] MASK_NARROW = 16'h003F;
  localparam logic [15:0] MASK_WIDE   = 16'h03FF;
  localparam logic [15:0] MASK_FULL   = 16'hFFFF;

  // Programmable select kinds.
  localparam logic [1:0] KIND_CS = 2'h0;
  localparam logic [1:0] KIND_LE = 2'h1;
  localparam logic [1:0] KIND_OE = 2'h2;

  // Strap tables, entry 0 rightmost, so a strap value indexes them directly.
  localparam logic [3:0][15:0] CFG_BASE_TAB  = {16'h0130, 16'h0120, 16'h0110, 16'h0100};
  localparam logic [3:0][7:0]  DFLT_CTRL_TAB = {8'hF2, 8'h01, 8'h31, 8'hF1};

  // Cycles waited after reset so that the strap synchronisers have settled.
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  // Bit positions in the synchronised pin vector.
  localparam int SYNC_W  = 8;
  localparam int SB_CFG  = 0;
  localparam int SB_BS0  = 2;
  localparam int SB_BS1  = 3;
  localparam int SB_IOW  = 4;
  localparam int SB_IOR  = 5;
  localparam int SB_DACK = 6;
  localparam int SB_AEN  = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'hF0;

  ////////////////////////////////////////////////////////////////////////////
  // Complete state of the decoder.
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [7:0]           idx;
    logic [2:0]           settle;
    logic                 straps_ok;
    logic                 rd_q;
    logic                 wr_q;
    logic [7:0]           dout;
    logic                 doe;
    logic [NFUNC-1:0]     fsel;
    logic                 dma_sel;
    logic [NPS-1:0]       psel;
  } icad_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } icad_sync_state_t;

endpackage : icad_pkg

`default_nettype wire

// File: icad_sync.sv
`timescale 1ns/100ps
`default_nettype none

module icad_sync (
  // Clock and reset.
  input  wire logic                          sys_clk_i,
  input  wire logic                          nrst_i,
  // Pins and their settled copies.
  input  wire logic [icad_pkg::SYNC_W-1:0]   pin_i,
  output logic      [icad_pkg::SYNC_W-1:0]   level_o
);

  icad_pkg::icad_sync_state_t st;
  icad_pkg::icad_sync_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Three stages; a bit only moves once the last two stages agree, so a
  // metastable first stage never reaches the decoder.
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < icad_pkg::SYNC_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  // Register the copy.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '{s1: icad_pkg::SYNC_RST, s2: icad_pkg::SYNC_RST, s3: icad_pkg::SYNC_RST, q: icad_pkg::SYNC_RST};
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.q;

endmodule : icad_sync

`default_nettype wire

// File: icad_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module icad_decoder (
  // Clock and reset.
  input  wire logic                        sys_clk_i,
  input  wire logic                        nrst_i,
  // Host bus.
  input  wire logic [15:0]                 addr_i,
  input  wire logic                        aen_i,
  input  wire logic                        ior_n_i,
  input  wire logic                        iow_n_i,
  input  wire logic                        dack_n_i,
  input  wire logic [7:0]                  data_i,
  output logic      [7:0]                  data_o,
  output logic                             data_oe_o,
  // Board straps.
  input  wire logic                        base_select_strap0_i,
  input  wire logic                        base_select_strap1_i,
  input  wire logic [1:0]                  default_config_strap_i,
  // Selects towards the function blocks and the board.
  output logic      [icad_pkg::NFUNC-1:0]  func_sel_o,
  output logic                             dma_sel_o,
  output logic                             prog_select_out0_n_o,
  output logic                             prog_select_out1_n_o
);

  icad_pkg::icad_state_t       st;
  icad_pkg::icad_state_t       next_st;
  logic [icad_pkg::SYNC_W-1:0] lvl;
  logic                        rd_act;
  logic                        wr_act;
  logic                        dma;
  logic                        host_ok;
  logic                        rd_ev;
  logic                        wr_ev;
  logic [1:0]                  mode;
  logic [15:0]                 mask;
  logic [15:0]                 cfg_base;
  logic                        idx_hit;
  logic                        dat_hit;
  logic                        idx_ok;

  ////////////////////////////////////////////////////////////////////////////
  // All pins that are not held stable by a strobe are synchronised.
  icad_sync u_icad_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     ({aen_i, dack_n_i, ior_n_i, iow_n_i, base_select_strap1_i,
                 base_select_strap0_i, default_config_strap_i}),
    .level_o   (lvl)
  );

  // Compares only the bits that the current decode width covers.
  function automatic logic icad_match(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
    return ((a ^ b) & m) == 16'h0000;
  endfunction : icad_match

  ////////////////////////////////////////////////////////////////////////////
  // Decode terms. Address and data are sampled at the strobe event; the bus
  // holds them for the whole strobe, which is far longer than the sync delay.
  assign rd_act   = ~lvl[icad_pkg::SB_IOR] & st.straps_ok;
  assign wr_act   = ~lvl[icad_pkg::SB_IOW] & st.straps_ok;
  assign rd_ev    = rd_act & ~st.rd_q;
  assign wr_ev    = wr_act & ~st.wr_q;
  assign dma      = ~lvl[icad_pkg::SB_DACK];                        // RULE5
  assign host_ok  = ~lvl[icad_pkg::SB_AEN] & ~dma;                  // RULE6
  assign mode     = st.regs[icad_pkg::REG_CTRL][icad_pkg::CTRL_MODE_LSB +: 2];
  assign mask     = (mode == icad_pkg::MODE_NARROW) ? icad_pkg::MASK_NARROW :
                    (mode == icad_pkg::MODE_WIDE)   ? icad_pkg::MASK_WIDE : icad_pkg::MASK_FULL; // RULE7
  assign cfg_base = {st.regs[icad_pkg::REG_CFGB_HI], st.regs[icad_pkg::REG_CFGB_LO]};           // RULE2
  assign idx_hit  = host_ok & icad_match(addr_i, cfg_base, mask);                                // RULE1
  assign dat_hit  = host_ok & icad_match(addr_i, cfg_base + 16'h0001, mask);                     // RULE1
  assign idx_ok   = int'(st.idx) < icad_pkg::NREG;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic [15:0] base;
    logic [7:0]  psmode;
    int          r;
    base    = 16'h0000;
    psmode  = 8'h00;
    r       = 0;
    next_st = st;
    next_st.rd_q = rd_act;
    next_st.wr_q = wr_act;

    // Straps are taken once the synchronisers have settled after reset.
    if (!st.straps_ok) begin
      next_st.settle = st.settle + 3'h1;
      if (st.settle == icad_pkg::SETTLE_CYC) begin
        next_st.straps_ok = 1'b1;
        next_st.regs[icad_pkg::REG_STRAP] = {4'h0, lvl[icad_pkg::SB_CFG +: 2],
                                             lvl[icad_pkg::SB_BS1], lvl[icad_pkg::SB_BS0]};
        {next_st.regs[icad_pkg::REG_CFGB_HI], next_st.regs[icad_pkg::REG_CFGB_LO]} =
          icad_pkg::CFG_BASE_TAB[{lvl[icad_pkg::SB_BS1], lvl[icad_pkg::SB_BS0]}];              // RULE3
        next_st.regs[icad_pkg::REG_CTRL] = icad_pkg::DFLT_CTRL_TAB[lvl[icad_pkg::SB_CFG +: 2]]; // RULE4
      end
    end

    // Selects stand for the length of the strobe.
    if (!rd_act && !wr_act) begin
      next_st.doe     = 1'b0;
      next_st.fsel    = '0;
      next_st.psel    = '0;
      next_st.dma_sel = 1'b0;
    end

    if (rd_ev || wr_ev) begin
      next_st.dma_sel = dma;                                         // RULE5
      for (int f = 0; f < icad_pkg::NFUNC; f++) begin
        r    = int'(icad_pkg::REG_FB) + f * icad_pkg::FB_STEP;
        base = {st.regs[r + 1], st.regs[r]};
        next_st.fsel[f] = host_ok & st.regs[icad_pkg::REG_CTRL][icad_pkg::CTRL_FEN_LSB + f]
                          & icad_match(addr_i, base, mask);          // RULE9
      end
      for (int n = 0; n < icad_pkg::NPS; n++) begin
        r      = int'(icad_pkg::REG_PS) + n * icad_pkg::PS_STEP;
        base   = {st.regs[r + 1], st.regs[r]};
        psmode = st.regs[r + 2];
        next_st.psel[n] = host_ok & (mode != icad_pkg::MODE_NARROW) & psmode[icad_pkg::PS_EN_BIT]
                          & icad_match(addr_i, base, mask)
                          & ((psmode[icad_pkg::PS_KIND_LSB +: 2] == icad_pkg::KIND_CS) |
                             ((psmode[icad_pkg::PS_KIND_LSB +: 2] == icad_pkg::KIND_LE) & wr_ev) |
                             ((psmode[icad_pkg::PS_KIND_LSB +: 2] == icad_pkg::KIND_OE) & rd_ev)); // RULE8
      end
    end

    // Index and data ports; a data access uses the latest index.
    if (rd_ev) begin
      if (idx_hit) begin
        next_st.dout = st.idx;
        next_st.doe  = 1'b1;
      end else if (dat_hit) begin
        next_st.dout = idx_ok ? st.regs[st.idx[icad_pkg::IDX_W-1:0]] : 8'h00;  // RULE10
        next_st.doe  = 1'b1;
      end
    end
    if (wr_ev) begin
      if (idx_hit) begin
        next_st.idx = data_i;                                        // RULE1
      end else if (dat_hit && idx_ok && st.idx != icad_pkg::REG_STRAP) begin
        next_st.regs[st.idx[icad_pkg::IDX_W-1:0]] = data_i;          // RULE2
      end
    end
  end

  // Register the copy.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops.
  assign data_o               = st.dout;
  assign data_oe_o            = st.doe;
  assign func_sel_o           = st.fsel;
  assign dma_sel_o            = st.dma_sel;
  assign prog_select_out0_n_o = ~st.psel[0];
  assign prog_select_out1_n_o = ~st.psel[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_index_write;
    wr_ev && idx_hit |=> st.idx == $past(data_i);
  endproperty
  a_index_write: assert property (p_index_write) else $error("Index port write lost."); // RULE1

  property p_reloc;
    wr_ev && dat_hit && st.idx == icad_pkg::REG_CFGB_LO |=> st.regs[icad_pkg::REG_CFGB_LO] == $past(data_i);
  endproperty
  a_reloc: assert property (p_reloc) else $error("Config port base not relocated."); // RULE2

  property p_base_strap;
    $rose(st.straps_ok) |-> cfg_base == icad_pkg::CFG_BASE_TAB[$past(lvl[icad_pkg::SB_BS0 +: 2])];
  endproperty
  a_base_strap: assert property (p_base_strap) else $error("Strap base not taken."); // RULE3

  property p_cfg_strap;
    $rose(st.straps_ok) |-> st.regs[icad_pkg::REG_CTRL] == icad_pkg::DFLT_CTRL_TAB[$past(lvl[icad_pkg::SB_CFG +: 2])];
  endproperty
  a_cfg_strap: assert property (p_cfg_strap) else $error("Default config not taken."); // RULE4

  property p_dma;
    (rd_ev || wr_ev) && dma |=> dma_sel_o && func_sel_o == '0 && !data_oe_o;
  endproperty
  a_dma: assert property (p_dma) else $error("DMA access decoded address."); // RULE5

  property p_aen;
    (rd_ev || wr_ev) && lvl[icad_pkg::SB_AEN] |=> func_sel_o == '0 && prog_select_out0_n_o && prog_select_out1_n_o;
  endproperty
  a_aen: assert property (p_aen) else $error("Selection while address enable high."); // RULE6

  property p_narrow;
    (rd_ev || wr_ev) && mode == icad_pkg::MODE_NARROW |=> prog_select_out0_n_o && prog_select_out1_n_o;
  endproperty
  a_narrow: assert property (p_narrow) else $error("Select asserted in narrow decode."); // RULE7

  property p_select_hold;
    !prog_select_out0_n_o && (rd_act || wr_act) |=> !prog_select_out0_n_o;
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("Select dropped inside strobe."); // RULE8

  property p_func_full;
    (rd_ev || wr_ev) && host_ok && mode == icad_pkg::MODE_FULL && st.regs[icad_pkg::REG_CTRL][icad_pkg::CTRL_FEN_LSB]
      && addr_i == {st.regs[icad_pkg::REG_FB + 8'h01], st.regs[icad_pkg::REG_FB]} |=> func_sel_o[0];
  endproperty
  a_func_full: assert property (p_func_full) else $error("Function base not matched."); // RULE9

  c_cfg_read: cover property (rd_ev && dat_hit ##1 data_oe_o);
  c_dma:      cover property (wr_ev && dma ##1 dma_sel_o);
  c_ps0:      cover property (!prog_select_out0_n_o);
  c_aen:      cover property ((rd_ev || wr_ev) && lvl[icad_pkg::SB_AEN]);

endmodule : icad_decoder

`default_nettype wire

// File: icad_host.sv
`timescale 1ns/100ps
`default_nettype none

module icad_host (
  // Clock.
  input  wire logic        sys_clk_i,
  // Host bus towards the decoder.
  output logic      [15:0] addr_o,
  output logic             aen_o,
  output logic             ior_n_o,
  output logic             iow_n_o,
  output logic             dack_n_o,
  output logic      [7:0]  data_o
);
  // Idle bus at time zero.
  initial begin
    addr_o   = 16'hFFFF;
    aen_o    = 1'b0;
    ior_n_o  = 1'b1;
    iow_n_o  = 1'b1;
    dack_n_o = 1'b1;
    data_o   = 8'hFF;
  end

  // One strobe; released lines flip so a late sample can never look right.
  task automatic access(input logic [15:0] a, input logic wr, input logic [7:0] d, input logic en, input logic dma);
    @(posedge sys_clk_i);
    addr_o   <= a;
    data_o   <= d;
    aen_o    <= en;
    dack_n_o <= ~dma;
    ior_n_o  <= wr;
    iow_n_o  <= ~wr;
    repeat (10) @(posedge sys_clk_i);
    ior_n_o  <= 1'b1;
    iow_n_o  <= 1'b1;
    dack_n_o <= 1'b1;
    @(posedge sys_clk_i);
    addr_o   <= ~a;
    data_o   <= ~d;
    aen_o    <= 1'b0;
    // Long idle gap so selects of this cycle clear before the next starts.
    repeat (8) @(posedge sys_clk_i);
  endtask : access

  // Index first, then the data port of the same pair.
  task automatic cfg(input logic [15:0] base, input logic [7:0] idx, input logic wr, input logic [7:0] v);
    access(base, 1'b1, idx, 1'b0, 1'b0);
    access(base + 16'h0001, wr, v, 1'b0, 1'b0);
  endtask : cfg
endmodule : icad_host

`default_nettype wire

// File: icad_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none

module icad_decoder_tb;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        bs0     = 1'b0;
  logic        bs1     = 1'b0;
  logic [1:0]  cfgs    = 2'h0;
  logic [15:0] addr;
  logic        aen;
  logic        ior_n;
  logic        iow_n;
  logic        dack_n;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        doe;
  logic [3:0]  fsel;
  logic        dma;
  logic        ps0_n;
  logic        ps1_n;
  logic [15:0] exp_q[$];
  logic [15:0] seen    = 16'h0000;
  logic [15:0] cbase, nb, old, fb, pa;
  logic [31:0] lfsr    = 32'h8B7C;
  bit          act     = 1'b0;
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  // Clock at 125 MHz.
  always #4 sys_clk = ~sys_clk;

  icad_host u_icad_host (.sys_clk_i(sys_clk), .addr_o(addr), .aen_o(aen), .ior_n_o(ior_n), .iow_n_o(iow_n),
    .dack_n_o(dack_n), .data_o(wdata));

  icad_decoder u_icad_decoder (.sys_clk_i(sys_clk), .nrst_i(nrst), .addr_i(addr), .aen_i(aen), .ior_n_i(ior_n),
    .iow_n_i(iow_n), .dack_n_i(dack_n), .data_i(wdata), .data_o(rdata), .data_oe_o(doe),
    .base_select_strap0_i(bs0), .base_select_strap1_i(bs1), .default_config_strap_i(cfgs),
    .func_sel_o(fsel), .dma_sel_o(dma), .prog_select_out0_n_o(ps0_n), .prog_select_out1_n_o(ps1_n));

  ////////////////////////////////////////////////////////////////////////////
  // Next value of the random source.
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction : nxt

  // Expected read answer: drive enable plus data, nothing else.
  function automatic logic [15:0] rd(input logic [7:0] v);
    return {1'b1, v, 7'h00};
  endfunction : rd

  // Counts one comparison; unknown bits in the result count as a mismatch.
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // Final report; the only place where the run ends.
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d, input logic en, input logic dm,
    input logic [15:0] e);
    exp_q.push_back(e);
    u_icad_host.access(a, wr, d, en, dm);
  endtask : bus

  // Indexed access; the bench follows any move of the port pair itself.
  task automatic cfg_acc(input logic [7:0] idx, input logic wr, input logic [7:0] v, input logic [15:0] e);
    exp_q.push_back(16'h0000);
    exp_q.push_back(e);
    u_icad_host.cfg(cbase, idx, wr, v);
    if (wr && idx == icad_pkg::REG_CFGB_LO) cbase[7:0] = v;
    if (wr && idx == icad_pkg::REG_CFGB_HI) cbase[15:8] = v;
  endtask : cfg_acc

  task automatic do_reset(input logic [1:0] bs, input logic [1:0] cf);
    @(posedge sys_clk);
    nrst <= 1'b0;
    bs0  <= bs[0];
    bs1  <= bs[1];
    cfgs <= cf;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    cbase = icad_pkg::CFG_BASE_TAB[bs];
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Gather everything the design shows during a strobe; judge it at release.
  always @(posedge sys_clk) begin
    if (!ior_n || !iow_n) begin
      seen = seen | {doe, 8'h00, fsel, dma, ~ps1_n, ~ps0_n};
      if (doe === 1'b1) seen[14:7] = rdata;
    end else if (act) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
      end else begin
        chk(exp_q.pop_front(), seen);
      end
      seen = 16'h0000;
    end
    act = !ior_n || !iow_n;
  end

  // Hang guard.
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end

  // Main sequence.
  initial begin
    for (int i = 3; i >= 0; i--) begin
      do_reset(2'(i), 2'(i));
      cfg_acc(icad_pkg::REG_STRAP, 1'b0, 8'h00, rd(8'({2'(i), 2'(i)})));
      cfg_acc(icad_pkg::REG_CTRL, 1'b0, 8'h00, rd(icad_pkg::DFLT_CTRL_TAB[i]));
    end
    cfg_acc(icad_pkg::REG_STRAP, 1'b1, 8'hFF, 16'h0000);
    cfg_acc(icad_pkg::REG_STRAP, 1'b0, 8'h00, rd(8'h00));
    cfg_acc(8'h20, 1'b0, 8'h00, rd(8'h00));
    // The index port reads back the index last written.
    bus(cbase, 1'b0, 8'h00, 1'b0, 1'b0, rd(8'h20));
    // Full width, then move the port pair to a random high place.
    cfg_acc(icad_pkg::REG_CTRL, 1'b1, 8'hF2, 16'h0000);
    lfsr = nxt(lfsr);
    nb = {1'b1, lfsr[8:0], 6'h2A};
    old = cbase;
    cfg_acc(icad_pkg::REG_CFGB_LO, 1'b1, nb[7:0], 16'h0000);
    cfg_acc(icad_pkg::REG_CFGB_HI, 1'b1, nb[15:8], 16'h0000);
    cfg_acc(icad_pkg::REG_CFGB_HI, 1'b0, 8'h00, rd(nb[15:8]));
    bus(old, 1'b1, icad_pkg::REG_CTRL, 1'b0, 1'b0, 16'h0000);
    bus(old + 16'h0001, 1'b0, 8'h00, 1'b0, 1'b0, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      fb = 16'h3F00 + 16'(f * 8);
      lfsr = nxt(lfsr);
      cfg_acc(8'(icad_pkg::REG_FB + 2 * f), 1'b1, fb[7:0], 16'h0000);
      cfg_acc(8'(icad_pkg::REG_FB + 2 * f + 1), 1'b1, fb[15:8], 16'h0000);
      bus(fb, 1'b0, 8'h00, 1'b0, 1'b0, 16'(1 << (f + 3)));
      bus(fb, 1'b1, lfsr[7:0], 1'b1, 1'b0, 16'h0000);
      bus(fb, 1'b0, 8'h00, 1'b1, 1'b1, 16'h0004);
      bus(lfsr[31:16], 1'b1, lfsr[7:0], 1'b0, 1'b1, 16'h0004);
    end
    // Each select in each kind, then refused under the narrow width.
    for (int n = 0; n < 2; n++) begin
      pa = 16'h0234 + 16'(n * 4);
      cfg_acc(8'(icad_pkg::REG_PS + 4 * n), 1'b1, pa[7:0], 16'h0000);
      cfg_acc(8'(icad_pkg::REG_PS + 4 * n + 1), 1'b1, pa[15:8], 16'h0000);
      for (int k = 0; k < 3; k++) begin
        lfsr = nxt(lfsr);
        cfg_acc(8'(icad_pkg::REG_PS + 4 * n + 2), 1'b1, 8'(k) | 8'h04, 16'h0000);
        bus(pa, 1'b0, 8'h00, 1'b0, 1'b0, (k != 1) ? 16'(1 << n) : 16'h0000);
        bus(pa, 1'b1, lfsr[7:0], 1'b0, 1'b0, (k != 2) ? 16'(1 << n) : 16'h0000);
      end
      cfg_acc(icad_pkg::REG_CTRL, 1'b1, 8'hF0, 16'h0000);
      bus(pa, 1'b0, 8'h00, 1'b0, 1'b0, 16'h0000);
      cfg_acc(icad_pkg::REG_CTRL, 1'b1, 8'hF1, 16'h0000);
      bus(pa, 1'b0, 8'h00, 1'b0, 1'b0, 16'(1 << n));
      cfg_acc(icad_pkg::REG_CTRL, 1'b1, 8'hF2, 16'h0000);
      cfg_acc(8'(icad_pkg::REG_PS + 4 * n + 2), 1'b1, 8'h00, 16'h0000);
    end
    repeat (10) @(posedge sys_clk);
    if (exp_q.size() != 0) n_mismatch++;
    test_done();
  end
endmodule : icad_decoder_tb

`default_nettype wire
